// ---- tx_fifo_pkg.sv ----
/*
 * Shared constants and types for the transmit frame FIFO and its partner.
 * Assumes both ends and the link interface are compiled after this package.
 */
package tx_fifo_pkg;
    // ************************************************************
    // Word layout
    // ************************************************************
    localparam int WORD_W = 64;
    localparam int EMPTY_W = 3;
    localparam int BYTES_PER_WORD = 8;
    localparam int DEPTH_DEFAULT = 512;

    // Bit positions of the packed storage entry
    localparam int ENTRY_EMPTY_LSB = WORD_W;
    localparam int ENTRY_FIRST_BIT = WORD_W + EMPTY_W;
    localparam int ENTRY_LAST_BIT = WORD_W + EMPTY_W + 1;
    localparam int ENTRY_ERROR_BIT = WORD_W + EMPTY_W + 2;
    localparam int ENTRY_W = WORD_W + EMPTY_W + 3;

    // ************************************************************
    // Operating modes and reset values
    // ************************************************************
    typedef enum logic [0:0] {
        MODE_STORE_FORWARD = 1'b0,
        MODE_FILL_LEVEL = 1'b1
    } fifo_mode_t;

    localparam logic READY_RESET = 1'b1;
    localparam logic AVAIL_RESET = 1'b0;

    // ************************************************************
    // Partner register map (byte addresses)
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] REG_TX_WORD_LO = 8'h00;
    localparam logic [7:0] REG_TX_WORD_HI = 8'h04;
    localparam logic [7:0] REG_TX_CTRL = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RX_WORD_LO = 8'h10;
    localparam logic [7:0] REG_RX_WORD_HI = 8'h14;
    localparam logic [7:0] REG_RX_INFO = 8'h18;
    localparam logic [7:0] REG_MAC_CTRL = 8'h1c;

    // Control and info field positions
    localparam int CTRL_FIRST_BIT = 0;
    localparam int CTRL_LAST_BIT = 1;
    localparam int CTRL_EMPTY_LSB = 2;
    localparam int CTRL_ERROR_BIT = 5;
    localparam int INFO_VALID_BIT = 8;
    localparam int MAC_CTRL_ENABLE_BIT = 0;
    localparam int STATUS_PENDING_BIT = 0;
    localparam int STATUS_READY_BIT = 1;
    localparam int STATUS_AVAIL_BIT = 2;
    localparam int STATUS_RX_VALID_BIT = 3;
endpackage

// ---- tx_stream_if.sv ----
/*
 * Link between the transmit frame FIFO and its partner logic.
 * Assumes one shared clock; the client and MAC halves both sit in the partner.
 */
`timescale 1ns/1ns
interface tx_stream_if;
    // ************************************************************
    // Client write side
    // ************************************************************
    logic [tx_fifo_pkg::WORD_W-1:0] client_write_word;
    logic client_write_valid;
    logic client_frame_first;
    logic client_frame_last;
    logic [tx_fifo_pkg::EMPTY_W-1:0] client_empty_bytes;
    logic client_frame_error;
    logic client_side_ready_flag;

    // ************************************************************
    // MAC read side
    // ************************************************************
    logic mac_data_avail;
    logic mac_read_req;
    logic mac_word_valid;
    logic [tx_fifo_pkg::WORD_W-1:0] mac_word;
    logic mac_frame_first;
    logic mac_frame_last;
    logic [tx_fifo_pkg::EMPTY_W-1:0] mac_empty_bytes;
    logic mac_frame_error;

    modport fifo_end (
        input client_write_word, client_write_valid, client_frame_first,
        input client_frame_last, client_empty_bytes, client_frame_error,
        output client_side_ready_flag,
        output mac_data_avail, mac_word_valid, mac_word, mac_frame_first,
        output mac_frame_last, mac_empty_bytes, mac_frame_error,
        input mac_read_req
    );

    modport partner_end (
        output client_write_word, client_write_valid, client_frame_first,
        output client_frame_last, client_empty_bytes, client_frame_error,
        input client_side_ready_flag,
        input mac_data_avail, mac_word_valid, mac_word, mac_frame_first,
        input mac_frame_last, mac_empty_bytes, mac_frame_error,
        output mac_read_req
    );
endinterface

// ---- tx_frame_fifo.sv ----
/*
 * Transmit frame FIFO: buffers 64-bit client words and releases whole or
 * partly stored frames to the transmit MAC, steered by four byte thresholds.
 * Assumes the partner drives the client and MAC halves of tx_stream_if on
 * sys_clk, and that thresholds are static or change between frames.
 */
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ns

// Overview of operation
// - Write path and storage are 64 bits
// - Inputs count only while write-valid high
// - Client marks first word exactly once
// - Client marks last word exactly once
// - Empty-byte count stored with final word
// - Ready high while room remains
// - Backpressure only by dropping ready
// - Error mark travels with final word
// - Release words only on MAC request
// - Store mode: available after whole frame
// - Fill mode: threshold or frame end
// - Fill mode: drain without interruption
// - Client gaps allowed, MAC stream unbroken
// - Four programmable byte-count thresholds
// - Drop ready at almost-full-on
// - Raise ready at almost-full-off
// - Drop available at almost-empty-on
// - Raise available at almost-empty-off
// - Available flag alone gates MAC consumption; code also keeps reading mid-frame without it
// - Stop one cycle after request drops
// - Available only for deliverable frame
module tx_frame_fifo #(
    parameter int DEPTH = tx_fifo_pkg::DEPTH_DEFAULT,
    localparam int AW = $clog2(DEPTH),
    localparam int CNT_W = $clog2(DEPTH * tx_fifo_pkg::BYTES_PER_WORD) + 1
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    input wire tx_fifo_pkg::fifo_mode_t mode,
    input wire logic [CNT_W-1:0] almost_full_on,
    input wire logic [CNT_W-1:0] almost_full_off,
    input wire logic [CNT_W-1:0] almost_empty_on,
    input wire logic [CNT_W-1:0] almost_empty_off,
    output logic [CNT_W-1:0] stored_bytes,
    tx_stream_if.fifo_end link
);
    // ************************************************************
    // Declarations
    // ************************************************************
    localparam logic [CNT_W-1:0] CAPACITY = CNT_W'(DEPTH * tx_fifo_pkg::BYTES_PER_WORD);
    localparam logic [CNT_W-1:0] WORD_BYTES = CNT_W'(tx_fifo_pkg::BYTES_PER_WORD);

    logic [tx_fifo_pkg::ENTRY_W-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] frames;
    logic [AW:0] next_frames;
    logic [CNT_W-1:0] next_bytes;
    logic [CNT_W-1:0] next_free;
    logic [tx_fifo_pkg::ENTRY_W-1:0] head;
    logic in_frame;
    logic full;
    logic empty;
    logic wr_fire;
    logic rd_fire;
    logic ready;
    logic avail;
    logic out_valid;
    logic [tx_fifo_pkg::ENTRY_W-1:0] out_entry;

    // Bytes held by one word; a final word loses its empty lanes
    function automatic logic [CNT_W-1:0] word_bytes(
        input logic last,
        input logic [tx_fifo_pkg::EMPTY_W-1:0] empty_bytes
    );
        word_bytes = last ? WORD_BYTES - CNT_W'(empty_bytes) : WORD_BYTES;
    endfunction

    // ************************************************************
    // Pointer status and transfer strobes
    // ************************************************************
    // Full and empty from extended pointers
    assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    assign head = mem[rd_ptr[AW-1:0]];

    // A word is taken only with valid; full guards a late client
    assign wr_fire = ce && link.client_write_valid && !full;

    // Reads need the request, a non-empty FIFO and the available flag; once a frame
    // has started it is finished without regard to the flag
    assign rd_fire = ce && link.mac_read_req && (in_frame || avail) && !empty;

    // ************************************************************
    // Storage
    // ************************************************************
    // One 70-bit entry per word: the 64-bit word plus its markers
    always_ff @(posedge sys_clk) begin
        if (wr_fire) begin
            mem[wr_ptr[AW-1:0]] <= {link.client_frame_error && link.client_frame_last,
                                    link.client_frame_last,
                                    link.client_frame_first,
                                    link.client_empty_bytes,
                                    link.client_write_word};
        end
    end

    // Write pointer
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr <= '0;
        end else if (wr_fire) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    // Read pointer
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_ptr <= '0;
        end else if (rd_fire) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // ************************************************************
    // Occupancy bookkeeping
    // ************************************************************
    // Next byte and frame counts; next values keep the flags exact so a
    // drained last frame never leaves the flag high for one stray cycle
    always_comb begin
        next_bytes = stored_bytes;
        next_frames = frames;
        if (wr_fire) begin
            next_bytes = next_bytes + word_bytes(link.client_frame_last,
                                                 link.client_empty_bytes);
        end
        if (rd_fire) begin
            next_bytes = next_bytes - word_bytes(head[tx_fifo_pkg::ENTRY_LAST_BIT],
                head[tx_fifo_pkg::ENTRY_EMPTY_LSB +: tx_fifo_pkg::EMPTY_W]);
        end
        if (wr_fire && link.client_frame_last) begin
            next_frames = next_frames + 1'b1;
        end
        if (rd_fire && head[tx_fifo_pkg::ENTRY_LAST_BIT]) begin
            next_frames = next_frames - 1'b1;
        end
        next_free = CAPACITY - next_bytes;
    end

    // Byte occupancy, also shown to the user side
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stored_bytes <= '0;
        end else if (ce) begin
            stored_bytes <= next_bytes;
        end
    end

    // Count of complete frames held
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            frames <= '0;
        end else if (ce) begin
            frames <= next_frames;
        end
    end

    // Frame in progress toward the MAC
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            in_frame <= 1'b0;
        end else if (rd_fire) begin
            in_frame <= !head[tx_fifo_pkg::ENTRY_LAST_BIT];
        end
    end

    // ************************************************************
    // Client ready with hysteresis
    // ************************************************************
    // Less than a word of room also drops ready, whatever the thresholds
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ready <= tx_fifo_pkg::READY_RESET;
        end else if (ce) begin
            if (next_free <= almost_full_on || next_free < WORD_BYTES) begin
                ready <= 1'b0;
            end else if (next_free >= almost_full_off) begin
                ready <= 1'b1;
            end
        end
    end

    // ************************************************************
    // MAC data-available flag
    // ************************************************************
    // Store mode counts only whole frames; fill mode also opens on the
    // upper byte threshold and closes on the lower one
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            avail <= tx_fifo_pkg::AVAIL_RESET;
        end else if (ce) begin
            unique case (mode)
                tx_fifo_pkg::MODE_STORE_FORWARD: begin
                    avail <= (next_frames != '0);
                end
                tx_fifo_pkg::MODE_FILL_LEVEL: begin
                    if (next_frames != '0 || next_bytes >= almost_empty_off) begin
                        avail <= 1'b1;
                    end else if (next_bytes <= almost_empty_on) begin
                        avail <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // MAC read port
    // ************************************************************
    // Registered output: a dropped request ends words one cycle later
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            out_valid <= 1'b0;
        end else if (ce) begin
            out_valid <= rd_fire;
        end
    end

    // Word and markers of the last read
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            out_entry <= '0;
        end else if (rd_fire) begin
            out_entry <= head;
        end
    end

    // Link outputs, all straight from flip-flops
    assign link.client_side_ready_flag = ready;
    assign link.mac_data_avail = avail;
    assign link.mac_word_valid = out_valid;
    assign link.mac_word = out_entry[tx_fifo_pkg::WORD_W-1:0];
    assign link.mac_empty_bytes = out_entry[tx_fifo_pkg::ENTRY_EMPTY_LSB +: tx_fifo_pkg::EMPTY_W];
    assign link.mac_frame_first = out_entry[tx_fifo_pkg::ENTRY_FIRST_BIT];
    assign link.mac_frame_last = out_entry[tx_fifo_pkg::ENTRY_LAST_BIT];
    assign link.mac_frame_error = out_entry[tx_fifo_pkg::ENTRY_ERROR_BIT];
endmodule

// ---- tx_frame_partner.sv ----
/*
 * Partner end: a register-driven client packet source and a register-read
 * transmit MAC reader on the far side of tx_stream_if.
 * Assumes a bus master with one-cycle strobes and read data a cycle later.
 */
`timescale 1ns/1ns
module tx_frame_partner (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [tx_fifo_pkg::ADDR_W-1:0] addr,
    input wire logic [tx_fifo_pkg::DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [tx_fifo_pkg::DATA_W-1:0] rdata,
    tx_stream_if.partner_end link
);
    // ************************************************************
    // Declarations
    // ************************************************************
    logic [tx_fifo_pkg::WORD_W-1:0] tx_word;
    logic [tx_fifo_pkg::DATA_W-1:0] tx_ctrl;
    logic tx_pending;
    logic tx_valid;
    logic read_enable;
    logic mac_busy;
    logic read_req;
    logic [tx_fifo_pkg::WORD_W-1:0] rx_word;
    logic [7:0] rx_info;
    logic rx_valid;
    logic wr_ctrl;
    logic rd_info;

    assign wr_ctrl = ce && wr_stb && addr == tx_fifo_pkg::REG_TX_CTRL;
    assign rd_info = ce && rd_stb && addr == tx_fifo_pkg::REG_RX_INFO;

    // ************************************************************
    // Client source
    // ************************************************************
    // Staged word and markers written by software
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_word <= '0;
            tx_ctrl <= '0;
        end else if (ce && wr_stb) begin
            if (addr == tx_fifo_pkg::REG_TX_WORD_LO) begin
                tx_word[31:0] <= wdata;
            end
            if (addr == tx_fifo_pkg::REG_TX_WORD_HI) begin
                tx_word[63:32] <= wdata;
            end
            if (wr_ctrl) begin
                tx_ctrl <= wdata;
            end
        end
    end

    // A control write queues one word; it waits while ready is low
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_pending <= 1'b0;
        end else if (wr_ctrl) begin
            tx_pending <= 1'b1;
        end else if (ce && tx_pending && link.client_side_ready_flag) begin
            tx_pending <= 1'b0;
        end
    end

    // Valid for exactly one cycle per queued word
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_valid <= 1'b0;
        end else if (ce) begin
            tx_valid <= tx_pending && link.client_side_ready_flag && !wr_ctrl;
        end
    end

    assign link.client_write_word = tx_word;
    assign link.client_write_valid = tx_valid;
    assign link.client_frame_first = tx_ctrl[tx_fifo_pkg::CTRL_FIRST_BIT];
    assign link.client_frame_last = tx_ctrl[tx_fifo_pkg::CTRL_LAST_BIT];
    assign link.client_empty_bytes = tx_ctrl[tx_fifo_pkg::CTRL_EMPTY_LSB +: 3];
    assign link.client_frame_error = tx_ctrl[tx_fifo_pkg::CTRL_ERROR_BIT]
                                     && tx_ctrl[tx_fifo_pkg::CTRL_LAST_BIT];

    // ************************************************************
    // MAC reader
    // ************************************************************
    // Enable bit from software
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            read_enable <= 1'b0;
        end else if (ce && wr_stb && addr == tx_fifo_pkg::REG_MAC_CTRL) begin
            read_enable <= wdata[tx_fifo_pkg::MAC_CTRL_ENABLE_BIT];
        end
    end

    // Mid-frame tracker so a started frame is read to its end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mac_busy <= 1'b0;
        end else if (ce && link.mac_word_valid) begin
            mac_busy <= !link.mac_frame_last;
        end
    end

    // Request only on the available flag or inside a frame
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            read_req <= 1'b0;
        end else if (ce) begin
            read_req <= read_enable && (link.mac_data_avail || mac_busy);
        end
    end

    assign link.mac_read_req = read_req;

    // Last word seen; software may miss words if it reads slowly
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_word <= '0;
            rx_info <= '0;
        end else if (ce && link.mac_word_valid) begin
            rx_word <= link.mac_word;
            rx_info <= {2'h0, link.mac_frame_error, link.mac_empty_bytes,
                        link.mac_frame_last, link.mac_frame_first};
        end
    end

    // Capture flag: a new word wins over the clearing read
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_valid <= 1'b0;
        end else if (ce && link.mac_word_valid) begin
            rx_valid <= 1'b1;
        end else if (rd_info) begin
            rx_valid <= 1'b0;
        end
    end

    // ************************************************************
    // Register read port
    // ************************************************************
    // Data stands the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= '0;
            if (rd_stb) begin
                unique case (addr)
                    tx_fifo_pkg::REG_TX_WORD_LO: rdata <= tx_word[31:0];
                    tx_fifo_pkg::REG_TX_WORD_HI: rdata <= tx_word[63:32];
                    tx_fifo_pkg::REG_TX_CTRL: rdata <= tx_ctrl;
                    tx_fifo_pkg::REG_STATUS: rdata <= {28'h0000000, rx_valid,
                        link.mac_data_avail, link.client_side_ready_flag, tx_pending};
                    tx_fifo_pkg::REG_RX_WORD_LO: rdata <= rx_word[31:0];
                    tx_fifo_pkg::REG_RX_WORD_HI: rdata <= rx_word[63:32];
                    tx_fifo_pkg::REG_RX_INFO: rdata <= {23'h000000, rx_valid, rx_info};
                    tx_fifo_pkg::REG_MAC_CTRL: rdata <= {31'h00000000, read_enable};
                    default: rdata <= '0;
                endcase
            end
        end
    end
endmodule

// ---- tx_frame_fifo_checker.sv ----
/* Checker: assertions on the link between the FIFO and its partner.
   Assumes one clock, and srst synchronous and active high. */
`timescale 1ns/1ns
module tx_frame_fifo_checker (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic client_write_valid,
    input wire logic client_side_ready_flag,
    input wire logic mac_data_avail,
    input wire logic mac_read_req,
    input wire logic mac_word_valid,
    input wire logic mac_frame_first,
    input wire logic mac_frame_last,
    input wire logic mac_frame_error
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Tracks a frame in flight on the MAC side, so a first must follow a last
    logic in_frame;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            in_frame <= 1'b0;
        end else if (mac_word_valid) begin
            in_frame <= !mac_frame_last;
        end
    end
    // ****
    // Assertions
    // ****
    AST_RESET_STATE: assert property (disable iff (1'b0) srst |=>
        client_side_ready_flag && !mac_data_avail && !mac_word_valid)
        else $error("bad state after reset");
    AST_READ_NEEDS_REQ: assert property (mac_word_valid |-> $past(mac_read_req))
        else $error("word without request");
    AST_STOP_ON_DROP: assert property (!mac_read_req |=> !mac_word_valid)
        else $error("word after request dropped");
    AST_UNBROKEN: assert property (
        mac_word_valid && !mac_frame_last && mac_read_req |=> mac_word_valid)
        else $error("gap inside frame");
    AST_FRAME_DELIM: assert property (mac_word_valid |-> mac_frame_first == !in_frame)
        else $error("frame markers out of order");
    AST_ERROR_ON_LAST: assert property (mac_word_valid && mac_frame_error |-> mac_frame_last)
        else $error("error mark off last word");
    AST_START_NEEDS_AVAIL: assert property (
        mac_word_valid && mac_frame_first |-> $past(mac_data_avail))
        else $error("frame started without avail");
    AST_READY_CAUSE: assert property ($changed(client_side_ready_flag) |->
        $past(client_write_valid) || mac_word_valid)
        else $error("ready moved with no traffic");
    AST_AVAIL_RISE: assert property ($rose(mac_data_avail) |-> $past(client_write_valid))
        else $error("avail rose with no write");
    AST_AVAIL_FALL: assert property ($fell(mac_data_avail) |-> mac_word_valid)
        else $error("avail fell with no read");
endmodule

// ---- tx_frame_fifo_client_side_test.sv ----
/* Testbench: FIFO and partner joined by tx_stream_if, driven over the
   partner's register port. Assumes one 25 MHz clock and DEPTH 16. */
`timescale 1ns/1ns
module tx_frame_fifo_client_side_test;
    localparam int DEPTH = 16;
    localparam int CW = $clog2(DEPTH * tx_fifo_pkg::BYTES_PER_WORD) + 1;
    // Row: word, first, last, empty, error, avail expected (bit0 store, bit1 fill)
    typedef struct packed {
        logic [63:0] w;
        logic f;
        logic l;
        logic [2:0] e;
        logic er;
        logic [1:0] av;
    } row_t;
    row_t rows [4] = '{'{64'h0011223344556677, 1'b1, 1'b0, 3'h0, 1'b0, 2'h0},
        '{64'h8899aabbccddeeff, 1'b0, 1'b0, 3'h0, 1'b1, 2'h2},
        '{64'h0123456789abcdef, 1'b0, 1'b1, 3'h3, 1'b1, 2'h3},
        '{64'hfedcba9876543210, 1'b1, 1'b1, 3'h7, 1'b0, 2'h3}};
    row_t q [$];
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    tx_fifo_pkg::fifo_mode_t mode = tx_fifo_pkg::MODE_STORE_FORWARD;
    logic [CW-1:0] sb;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [31:0] rdata;
    int bad_count = 0;
    int samples_checked = 0;
    tx_stream_if link ();
    tx_frame_fifo #(.DEPTH(DEPTH)) i_tx_frame_fifo (.sys_clk(sys_clk), .srst(srst), .ce(ce),
        .mode(mode), .almost_full_on(8'h20), .almost_full_off(8'h40),
        .almost_empty_on(8'h00), .almost_empty_off(8'h10), .stored_bytes(sb), .link(link));
    tx_frame_partner i_tx_frame_partner (.sys_clk(sys_clk), .srst(srst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .link(link));
    tx_frame_fifo_checker i_tx_frame_fifo_checker (.sys_clk(sys_clk), .srst(srst),
        .client_write_valid(link.client_write_valid),
        .client_side_ready_flag(link.client_side_ready_flag),
        .mac_data_avail(link.mac_data_avail), .mac_read_req(link.mac_read_req),
        .mac_word_valid(link.mac_word_valid), .mac_frame_first(link.mac_frame_first),
        .mac_frame_last(link.mac_frame_last), .mac_frame_error(link.mac_frame_error));
    // ****
    // Clock, monitor and tasks
    // ****
    always #20 sys_clk = ~sys_clk;
    // Collects every word handed to the MAC, mid-cycle where outputs have settled
    always @(negedge sys_clk) begin
        if (link.mac_word_valid === 1'b1) begin
            q.push_back({link.mac_word, link.mac_frame_first, link.mac_frame_last,
                link.mac_empty_bytes, link.mac_frame_error, 2'h0});
        end
    end
    task automatic chk(input string nm, input logic [71:0] s, input logic [71:0] x);
        samples_checked++;
        if (s !== x) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        @(negedge sys_clk);
        d = rdata;
        @(posedge sys_clk);
    endtask
    // Three writes queue one word; the wait covers the partner's two-cycle push
    task automatic push(input row_t r);
        wr(tx_fifo_pkg::REG_TX_WORD_LO, r.w[31:0]);
        wr(tx_fifo_pkg::REG_TX_WORD_HI, r.w[63:32]);
        wr(tx_fifo_pkg::REG_TX_CTRL, {26'h0, r.er, r.e, r.l, r.f});
        repeat (3) @(posedge sys_clk);
    endtask
    // Lets the MAC read until n words arrived, bounded so a stall is reported
    task automatic drain(input int n);
        wr(tx_fifo_pkg::REG_MAC_CTRL, 32'h1);
        repeat (300) begin
            if (q.size() >= n) break;
            @(posedge sys_clk);
        end
        wr(tx_fifo_pkg::REG_MAC_CTRL, 32'h0);
        chk("word count", q.size(), n);
    endtask
    task automatic reset_check();
        logic [31:0] d;
        srst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        rd(tx_fifo_pkg::REG_STATUS, d);
        chk("status", d[3:0], 4'h2);
        chk("bytes", sb, 8'h00);
        rd(8'hf0, d);
        chk("unmapped", d, 32'h0);
    endtask
    // Pushes the rows in one mode, checks occupancy and avail, then drains
    task automatic run(input logic m);
        int n;
        logic [31:0] d;
        n = 0;
        mode <= tx_fifo_pkg::fifo_mode_t'(m);
        q.delete();
        for (int i = 0; i < 4; i++) begin
            push(rows[i]);
            n += rows[i].l ? 8 - int'(rows[i].e) : 8;
            chk("bytes", sb, 72'(n));
            rd(tx_fifo_pkg::REG_STATUS, d);
            chk("avail", d[2], rows[i].av[m]);
        end
        drain(4);
        for (int i = 0; i < 4; i++) begin
            chk("mac word", q[i], {rows[i][71:3], rows[i].er & rows[i].l, 2'h0});
        end
        chk("drained", sb, 8'h00);
    endtask
    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        reset_check();
        run(1'b0);
        run(1'b1);
        // Fill until free space meets the on threshold, exact boundary
        mode <= tx_fifo_pkg::MODE_STORE_FORWARD;
        q.delete();
        for (int i = 0; i < 12; i++) begin
            push({64'(i), i == 0, i == 11, 3'h0, 1'b0, 2'h0});
            chk("ready", link.client_side_ready_flag, i < 11);
        end
        drain(12);
        chk("ready again", link.client_side_ready_flag, 1'b1);
        // Reset in the middle of a frame; a write while frozen must not queue
        push(rows[0]);
        ce <= 1'b0;
        wr(tx_fifo_pkg::REG_TX_CTRL, 32'h2);
        ce <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("frozen", sb, 8'h08);
        reset_check();
        wrap_up();
    end
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        wrap_up();
    end
endmodule
